// file: core/bank_mem_pkg.sv
package bank_mem_pkg;

    // ****************************************
    // Address map
    // ****************************************
    localparam int ADDR_W = 9;
    localparam int INBANK_W = 7;
    localparam int DATA_W = 8;
    localparam int BANK_COUNT = 4;
    localparam logic [6:0] INBANK_TOP = 7'h7F;
    localparam logic [6:0] STATUS_OFFSET = 7'h03;
    localparam logic [6:0] POINTER_OFFSET = 7'h04;
    localparam int SFR_SPAN_DEFAULT = 32;

    // ****************************************
    // Status field positions and reset values
    // ****************************************
    localparam int IRP_BIT = 7;
    localparam int RP_HI_BIT = 6;
    localparam int RP_LO_BIT = 5;
    localparam int WDT_BIT = 4;
    localparam int SLEEP_BIT = 3;
    localparam int ZERO_BIT = 2;
    localparam int NIBBLE_BIT = 1;
    localparam int MSB_BIT = 0;
    localparam logic [2:0] BANK_CTRL_RESET = 3'h0;
    localparam logic [1:0] CAUSE_RESET = 2'h3;
    localparam logic [2:0] FLAGS_RESET = 3'h0;
    localparam logic [7:0] POINTER_RESET = 8'h00;
    localparam logic [7:0] READ_ZERO = 8'h00;

    // ****************************************
    // Types
    // ****************************************
    typedef enum logic [1:0] {
        ALU_NONE,
        ALU_LOGIC,
        ALU_ADD,
        ALU_SUB
    } alu_op_t;

    typedef struct packed {
        logic valid;
        logic write;
        logic indirect;
        logic [6:0] operand;
        logic [7:0] wdata;
        alu_op_t alu_op;
        logic [7:0] alu_a;
        logic [7:0] alu_b;
    } core_req_t;

    typedef struct packed {
        logic watchdog_clear;
        logic sleep_exec;
        logic watchdog_timeout;
    } hw_evt_t;

endpackage

// file: core/banked_data_memory_status.sv
`timescale 1ns/1ns
// Contract
// - Status bits 6:5 pick the bank for direct addressing, 00 to 11.
// - Each bank holds 128 bytes addressed by a 7-bit in-bank address.
// - Low in-bank locations are special registers, the rest static RAM.
// - Frequently used special registers appear at the same offset in all banks.
// - Status is reachable at 03h, 83h, 103h and 183h.
// - Every location is reachable directly and through the pointer.
// - Status accepts writes from any instruction like other registers.
// - Flag-updating instructions suppress data writes to the three flags.
// - Watchdog and sleep cause bits ignore writes; only hardware events move them.
// - Clearing status clears bits 7:5, keeps causes and carries, sets zero.
// - In subtraction the carry flags mean not-borrow.
// - Reset loads 0 into page and bank bits, 1 into cause bits.
// - Page bit 1 reaches banks 2 and 3, 0 reaches banks 0 and 1.
// - Sleep flag set by power-up or watchdog clear, cleared by sleep.
// - Zero flag follows whether the result is zero.
// - Nibble flag is the carry out of bit 3 on add and subtract.
// - Msb flag is the carry out of bit 7 on add and subtract.
module banked_data_memory_status
    import bank_mem_pkg::*;
#(
    parameter int SFR_SPAN = SFR_SPAN_DEFAULT
)
(
    // Clock and reset
    input wire logic core_clk_in,
    input wire logic rst_in,
    // Core access
    input wire core_req_t req_in,
    input wire hw_evt_t evt_in,
    output logic [7:0] rdata_out,
    output logic rvalid_out,
    // State seen by the core
    output logic [7:0] status_out,
    output logic [7:0] pointer_out,
    output logic [7:0] result_out
);

    // ****************************************
    // Parameter check
    // ****************************************
    if (SFR_SPAN <= int'(POINTER_OFFSET) || SFR_SPAN > int'(INBANK_TOP))
    begin : g_bad_span
        $error("SFR_SPAN must cover the mirrored registers and leave RAM");
    end

    // ****************************************
    // Storage
    // ****************************************
    logic [7:0] status;
    logic [2:0] bank_ctrl;
    logic [1:0] cause;
    logic [2:0] flags;
    logic [7:0] pointer;
    logic [7:0] ram [0:(1 << ADDR_W) - 1];

    // ****************************************
    // Address formation
    // ****************************************
    logic [8:0] direct_addr;
    logic [8:0] indirect_addr;
    logic [8:0] addr;
    logic [6:0] inbank;
    logic hit_status;
    logic hit_pointer;
    logic hit_sfr;

    // Bank bits on top of the operand, page bit on top of the pointer
    assign direct_addr = {status[RP_HI_BIT], status[RP_LO_BIT],
        req_in.operand};
    assign indirect_addr = {status[IRP_BIT], pointer};
    assign addr = req_in.indirect ? indirect_addr : direct_addr;
    assign inbank = addr[INBANK_W-1:0];

    // Mirrored registers decode on the in-bank offset only
    assign hit_status = (inbank == STATUS_OFFSET);
    assign hit_pointer = (inbank == POINTER_OFFSET);
    assign hit_sfr = (inbank < 7'(SFR_SPAN));

    // ****************************************
    // Arithmetic flag generation
    // ****************************************
    logic [4:0] nib_sum;
    logic [8:0] full_sum;
    logic [7:0] b_eff;
    logic c_in;
    logic [7:0] result;
    logic arith;

    // Subtraction adds the two's complement, so carries read as not-borrow
    assign arith = (req_in.alu_op == ALU_ADD) || (req_in.alu_op == ALU_SUB);
    assign b_eff = (req_in.alu_op == ALU_SUB) ? ~req_in.alu_b
        : req_in.alu_b;
    assign c_in = (req_in.alu_op == ALU_SUB);
    assign nib_sum = {1'b0, req_in.alu_a[3:0]} + {1'b0, b_eff[3:0]}
        + {4'h0, c_in};
    assign full_sum = {1'b0, req_in.alu_a} + {1'b0, b_eff}
        + {8'h00, c_in};
    assign result = arith ? full_sum[7:0] : req_in.wdata;

    // ****************************************
    // Status register
    // ****************************************
    logic wr_status;
    logic flag_op;

    assign wr_status = req_in.valid && req_in.write && hit_status;
    assign flag_op = req_in.valid && (req_in.alu_op != ALU_NONE);

    // Page and bank bits take plain data writes
    always_ff @(posedge core_clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            bank_ctrl <= BANK_CTRL_RESET;
        end
        else if (wr_status)
        begin
            bank_ctrl <= result[7:5];
        end
    end

    // Cause bits move only on hardware events, sets win
    always_ff @(posedge core_clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            cause <= CAUSE_RESET;
        end
        else
        begin
            if (evt_in.watchdog_clear || evt_in.sleep_exec)
            begin
                cause[1] <= 1'b1;
            end
            else if (evt_in.watchdog_timeout)
            begin
                cause[1] <= 1'b0;
            end
            if (evt_in.watchdog_clear)
            begin
                cause[0] <= 1'b1;
            end
            else if (evt_in.sleep_exec)
            begin
                cause[0] <= 1'b0;
            end
        end
    end

    // Flags follow the ALU; data writes reach them only without an ALU op
    always_ff @(posedge core_clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            flags <= FLAGS_RESET;
        end
        else if (flag_op)
        begin
            flags[ZERO_BIT] <= (result == 8'h00);
            if (arith)
            begin
                flags[NIBBLE_BIT] <= nib_sum[4];
                flags[MSB_BIT] <= full_sum[8];
            end
        end
        else if (wr_status)
        begin
            flags <= result[2:0];
        end
    end

    // ****************************************
    // Pointer and RAM
    // ****************************************
    always_ff @(posedge core_clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            pointer <= POINTER_RESET;
        end
        else if (req_in.valid && req_in.write && hit_pointer)
        begin
            pointer <= result;
        end
    end

    // General purpose bytes above the special register span
    always_ff @(posedge core_clk_in)
    begin
        if (req_in.valid && req_in.write && !hit_sfr)
        begin
            ram[addr] <= result;
        end
    end

    // ****************************************
    // Read path and result
    // ****************************************
    logic [7:0] next_rdata;

    // Other special registers live elsewhere and read as zero here
    always_comb
    begin
        if (hit_status)
        begin
            next_rdata = status;
        end
        else if (hit_pointer)
        begin
            next_rdata = pointer;
        end
        else if (hit_sfr)
        begin
            next_rdata = READ_ZERO;
        end
        else
        begin
            next_rdata = ram[addr];
        end
    end

    always_ff @(posedge core_clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            rdata_out <= READ_ZERO;
            rvalid_out <= 1'b0;
            result_out <= READ_ZERO;
        end
        else
        begin
            rvalid_out <= req_in.valid && !req_in.write;
            if (req_in.valid && !req_in.write)
            begin
                rdata_out <= next_rdata;
            end
            if (flag_op)
            begin
                result_out <= result;
            end
        end
    end

    assign status = {bank_ctrl, cause, flags}; // One driver per field group
    assign status_out = status;
    assign pointer_out = pointer;

    // ****************************************
    // Checks
    // ****************************************
    sequence s_ram_write;
        req_in.valid && req_in.write && !hit_sfr;
    endsequence

    sequence s_same_read;
        req_in.valid && !req_in.write && addr == $past(addr);
    endsequence

    property p_ram_roundtrip;
        @(posedge core_clk_in) disable iff (rst_in)
        s_ram_write ##1 s_same_read |=> rdata_out == $past(result, 2);
    endproperty
    a_ram_roundtrip: assert property (p_ram_roundtrip)
        else $error("RAM read did not return written byte");

    property p_status_mirror;
        @(posedge core_clk_in) disable iff (rst_in)
        req_in.valid && !req_in.write && inbank == STATUS_OFFSET
        |=> rdata_out == $past(status);
    endproperty
    a_status_mirror: assert property (p_status_mirror)
        else $error("Status mirror read wrong");

    property p_bank_write;
        @(posedge core_clk_in) disable iff (rst_in)
        wr_status |=> status[6:5] == $past(result[6:5]);
    endproperty
    a_bank_write: assert property (p_bank_write)
        else $error("Bank bits not written");

    property p_cause_hold;
        @(posedge core_clk_in) disable iff (rst_in)
        evt_in == 3'b000 |=> $stable(status[4:3]);
    endproperty
    a_cause_hold: assert property (p_cause_hold)
        else $error("Cause bits moved without event");

    property p_clear_status;
        @(posedge core_clk_in) disable iff (rst_in)
        wr_status && req_in.alu_op == ALU_LOGIC && req_in.wdata == 8'h00
        |=> status[7:5] == 3'b000 && status[ZERO_BIT]
            && status[1:0] == $past(status[1:0]);
    endproperty
    a_clear_status: assert property (p_clear_status)
        else $error("Clearing status gave wrong pattern");

    property p_sleep_clears;
        @(posedge core_clk_in) disable iff (rst_in)
        evt_in.sleep_exec && !evt_in.watchdog_clear |=> !status[SLEEP_BIT];
    endproperty
    a_sleep_clears: assert property (p_sleep_clears)
        else $error("Sleep flag not cleared");

    property p_sub_borrow;
        @(posedge core_clk_in) disable iff (rst_in)
        req_in.valid && req_in.alu_op == ALU_SUB
        |=> status[MSB_BIT] == ($past(req_in.alu_a) >= $past(req_in.alu_b))
            && status[NIBBLE_BIT]
            == ($past(req_in.alu_a[3:0]) >= $past(req_in.alu_b[3:0]));
    endproperty
    a_sub_borrow: assert property (p_sub_borrow)
        else $error("Subtract borrow flags wrong");

    property p_zero_flag;
        @(posedge core_clk_in) disable iff (rst_in)
        flag_op |=> status[ZERO_BIT] == (result_out == 8'h00);
    endproperty
    a_zero_flag: assert property (p_zero_flag)
        else $error("Zero flag disagrees with result");

    property p_reset_values;
        @(posedge core_clk_in)
        $past(rst_in) && !rst_in
        |-> status[7:5] == 3'b000 && status[4:3] == 2'b11;
    endproperty
    a_reset_values: assert property (p_reset_values)
        else $error("Status reset values wrong");

endmodule

// file: sim/core_model.sv
`timescale 1ns/1ns
module core_model
    import bank_mem_pkg::*;
(
    // Clock
    input wire logic core_clk_in,
    // Answer from the memory
    input wire logic [7:0] rdata_in,
    input wire logic rvalid_in,
    // Requests and events
    output core_req_t req_out,
    output hw_evt_t evt_out
);
    // Idle from time zero
    initial
    begin
        req_out = '0;
        evt_out = '0;
    end

    // One access held over its taking edge, status changed safely
    task automatic access(input logic wr, input logic ind,
        input logic [6:0] op, input logic [7:0] d, input alu_op_t f,
        input logic [7:0] a, input logic [7:0] b);
        @(posedge core_clk_in);
        #10;
        req_out = {1'b1, wr, ind, op, d, f, a, b};
        @(posedge core_clk_in);
        #10;
        req_out = {1'b0, ~req_out[$bits(core_req_t)-2:0]};
    endtask

    // Read, answer taken just after the edge
    task automatic read(input logic ind, input logic [6:0] op,
        output logic [7:0] d, output logic ok);
        access(1'b0, ind, op, 8'h00, ALU_NONE, 8'h00, 8'h00);
        ok = rvalid_in;
        d = rdata_in;
    endtask

    // Write then read one location on consecutive edges
    task automatic write_read(input logic ind, input logic [6:0] op,
        input logic [7:0] wd, output logic [7:0] d, output logic ok);
        @(posedge core_clk_in);
        #10;
        req_out = {1'b1, 1'b1, ind, op, wd, ALU_NONE, 8'h00, 8'h00};
        @(posedge core_clk_in);
        #10;
        req_out = {1'b1, 1'b0, ind, op, 8'h00, ALU_NONE, 8'h00, 8'h00};
        @(posedge core_clk_in);
        #10;
        req_out = {1'b0, ~req_out[$bits(core_req_t)-2:0]};
        ok = rvalid_in;
        d = rdata_in;
    endtask

    // One-cycle hardware event
    task automatic pulse(input hw_evt_t e);
        @(posedge core_clk_in);
        #10;
        evt_out = e;
        @(posedge core_clk_in);
        #10;
        evt_out = '0;
    endtask
endmodule

// file: sim/tb.sv
`timescale 1ns/1ns
module tb;
    import bank_mem_pkg::*;
    logic core_clk_in;
    logic rst_in;
    core_req_t req;
    hw_evt_t evt;
    logic [7:0] rdata, st, ptr, res, exp_st, d;
    logic rvalid, ok;
    int n_mismatch, n_tests, cycles;
    logic [7:0] va [4] = '{8'h0F, 8'hFF, 8'h05, 8'h03};
    logic [7:0] vb [4] = '{8'h01, 8'h01, 8'h03, 8'h05};

    // ****************************************
    // Clock, instances and timeout
    // ****************************************
    initial
    begin
        core_clk_in = 1'b0;
        forever #50 core_clk_in = ~core_clk_in;
    end

    banked_data_memory_status uut (.core_clk_in(core_clk_in),
        .rst_in(rst_in), .req_in(req), .evt_in(evt), .rdata_out(rdata),
        .rvalid_out(rvalid), .status_out(st), .pointer_out(ptr),
        .result_out(res));

    core_model core (.core_clk_in(core_clk_in), .rdata_in(rdata),
        .rvalid_in(rvalid), .req_out(req), .evt_out(evt));

    // Cut a hang short
    always @(posedge core_clk_in)
    begin
        cycles++;
        if (cycles == 3000)
        begin
            n_mismatch++;
            end_of_test();
        end
    end

    // ****************************************
    // Tasks
    // ****************************************
    task automatic chk(input logic [7:0] got, input logic [7:0] exp,
        input string m);
        n_tests++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("unexpected at %0t: %s got %h exp %h", $time, m, got,
                exp);
        end
    endtask

    task automatic rd_chk(input logic ind, input logic [6:0] op,
        input logic [7:0] exp);
        core.read(ind, op, d, ok);
        chk({7'h00, ok}, 8'h01, "rvalid");
        chk(d, exp, "read data");
    endtask

    task automatic wr(input logic [6:0] op, input logic [7:0] v);
        core.access(1'b1, 1'b0, op, v, ALU_NONE, 8'h00, 8'h00);
    endtask

    task automatic bank(input logic [1:0] b);
        exp_st[6:5] = b;
        wr(STATUS_OFFSET, exp_st);
    endtask

    // Add or subtract to RAM, flags from own arithmetic
    task automatic alu(input logic sub, input logic [7:0] a,
        input logic [7:0] b);
        logic [7:0] bb;
        logic [8:0] s;
        logic [4:0] n;
        bb = sub ? ~b : b;
        s = {1'b0, a} + {1'b0, bb} + {8'h00, sub};
        n = {1'b0, a[3:0]} + {1'b0, bb[3:0]} + {4'h0, sub};
        core.access(1'b1, 1'b0, 7'h20, 8'h00, sub ? ALU_SUB : ALU_ADD, a, b);
        exp_st[2:0] = {s[7:0] == 8'h00, n[4], s[8]};
        chk(st, exp_st, "alu flags");
        chk(res, s[7:0], "alu result");
    endtask

    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    // ****************************************
    // Main sequence
    // ****************************************
    initial
    begin
        rst_in = 1'b1;
        repeat (16) @(posedge core_clk_in);
        #10 rst_in = 1'b0;
        exp_st = 8'h18;
        chk(st, exp_st, "reset status");
        chk(ptr, 8'h00, "reset pointer");
        $display("test reset done");
        for (int b = 0; b < 4; b++)
        begin
            bank(b[1:0]);
            wr(7'h20, 8'hA0 + b[7:0]);
            wr(INBANK_TOP, 8'hB0 + b[7:0]);
            rd_chk(1'b0, STATUS_OFFSET, exp_st);
        end
        for (int b = 0; b < 4; b++)
        begin
            bank(b[1:0]);
            rd_chk(1'b0, 7'h20, 8'hA0 + b[7:0]);
            rd_chk(1'b0, INBANK_TOP, 8'hB0 + b[7:0]);
        end
        wr(7'h10, 8'h55);
        rd_chk(1'b0, 7'h10, 8'h00);
        $display("test banks done");
        wr(POINTER_OFFSET, 8'hA0);
        chk(ptr, 8'hA0, "pointer");
        rd_chk(1'b1, 7'h00, 8'hA1);
        exp_st[7] = 1'b1;
        wr(STATUS_OFFSET, exp_st);
        rd_chk(1'b1, 7'h00, 8'hA3);
        rd_chk(1'b0, POINTER_OFFSET, 8'hA0);
        core.write_read(1'b1, 7'h00, 8'h5A, d, ok);
        chk({7'h00, ok}, 8'h01, "rvalid back to back");
        chk(d, 8'h5A, "indirect write");
        rd_chk(1'b0, 7'h20, 8'h5A);
        $display("test indirect done");
        core.pulse(3'h2);
        exp_st[4:3] = 2'h2;
        chk(st, exp_st, "sleep");
        wr(STATUS_OFFSET, 8'h00);
        exp_st = {3'h0, exp_st[4:3], 3'h0};
        chk(st, exp_st, "write zero");
        wr(STATUS_OFFSET, 8'hFF);
        exp_st = {3'h7, exp_st[4:3], 3'h7};
        chk(st, exp_st, "write ones");
        core.access(1'b1, 1'b0, STATUS_OFFSET, 8'h00, ALU_LOGIC, 8'h00,
            8'h00);
        exp_st = {3'h0, exp_st[4:3], 1'b1, exp_st[1:0]};
        chk(st, exp_st, "clear status");
        core.pulse(3'h1);
        exp_st[4] = 1'b0;
        chk(st, exp_st, "timeout");
        core.pulse(3'h4);
        exp_st[4:3] = 2'h3;
        chk(st, exp_st, "watchdog clear");
        $display("test status done");
        for (int i = 0; i < 4; i++)
            alu(i >= 2, va[i], vb[i]);
        $display("test alu done");
        end_of_test();
    end
endmodule
